// File: rtl/sadec_system_address_decoder.sv
/*
 * system address decoder: classifies each host memory or i/o cycle, selects
 * the on-board target, forwards channel cycles and holds the dma page file.
 * assumes host requests are single-cycle strobes on mclk; card width strobes
 * arrive asynchronously from the expansion slots.
 */
`timescale 1ns/1ps
`default_nettype none

module sadec_system_address_decoder #(
	parameter logic [23:0] BOARD_MEM_LIMIT = sadec_pkg::MEM_BOARD_LIMIT
) (
	input  wire logic                        mclk,
	input  wire logic                        rst_b,
	input  wire sadec_pkg::sadec_host_cycle_s hostCyc,
	input  wire logic                        shadowAdapterEn,
	input  wire logic                        shadowSystemEn,
	input  wire logic                        memCs16_b,
	input  wire logic                        ioCs16_b,
	output logic                             ansValid,
	output sadec_pkg::sadec_target_e         route,
	output sadec_pkg::sadec_exp_cycle_s      expCyc,
	output logic                             ioRdataValid,
	output logic [7:0]                       ioRdata,
	output logic                             coprocClearBusy,
	output logic                             coprocReset,
	output logic [sadec_pkg::PAGE_NUM-1:0][7:0] pageOut
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]                  memSync;
		logic [2:0]                  ioSync;
		logic                        memFilt_b;
		logic                        ioFilt_b;
		logic                        ansValid;
		sadec_pkg::sadec_target_e    route;
		sadec_pkg::sadec_exp_cycle_s exp;
		logic                        rdValid;
		logic                        clrBusy;
		logic                        copReset;
	} sadec_state_s;

	sadec_state_s st;
	sadec_state_s next_st;

	// ----------------------------------------------------------------
	// decode functions
	// ----------------------------------------------------------------

	// memory map classification
	function automatic sadec_pkg::sadec_target_e decodeMem(
		input logic [23:0] a,
		input logic        shA,
		input logic        shS
	);
		if (a <= sadec_pkg::MEM_LOW_END) begin
			decodeMem = sadec_pkg::TGT_SYSMEM;
		end else if (a <= sadec_pkg::MEM_CONV_END) begin
			decodeMem = sadec_pkg::TGT_SYSMEM;
		end else if (a < sadec_pkg::MEM_ADPROM_BASE) begin
			decodeMem = sadec_pkg::TGT_EXPANSION;
		end else if (a <= sadec_pkg::MEM_ADPROM_END) begin
			decodeMem = shA ? sadec_pkg::TGT_ADPSHADOW : sadec_pkg::TGT_ADPROM;
		end else if (a <= sadec_pkg::MEM_BIOS_END) begin
			decodeMem = shS ? sadec_pkg::TGT_SYSSHADOW : sadec_pkg::TGT_SYSROM;
		end else if (a < BOARD_MEM_LIMIT) begin
			decodeMem = sadec_pkg::TGT_SYSMEM;
		end else begin
			decodeMem = sadec_pkg::TGT_EXPANSION;
		end
	endfunction

	// board i/o classification, 000-0FF only
	function automatic sadec_pkg::sadec_target_e decodeBoardIo(input logic [9:0] a);
		if (a <= sadec_pkg::IO_DMA1_HI) begin
			decodeBoardIo = sadec_pkg::TGT_DMA1;
		end else if (a <= sadec_pkg::IO_PIC1_HI) begin
			decodeBoardIo = sadec_pkg::TGT_PIC1;
		end else if (a <= sadec_pkg::IO_TIMER_HI) begin
			decodeBoardIo = sadec_pkg::TGT_TIMER;
		end else if (a <= sadec_pkg::IO_KBC_HI) begin
			decodeBoardIo = sadec_pkg::TGT_KBC;
		end else if (a <= sadec_pkg::IO_RTC_HI) begin
			decodeBoardIo = sadec_pkg::TGT_RTC;
		end else if (a <= sadec_pkg::IO_PAGE_HI) begin
			decodeBoardIo = sadec_pkg::TGT_PAGE;
		end else if (a <= sadec_pkg::IO_PIC2_HI) begin
			decodeBoardIo = sadec_pkg::TGT_PIC2;
		end else if (a <= sadec_pkg::IO_DMA2_HI) begin
			decodeBoardIo = sadec_pkg::TGT_DMA2;
		end else if (a == sadec_pkg::IO_COPRO_CLR) begin
			decodeBoardIo = sadec_pkg::TGT_COPRO_CLR;
		end else if (a == sadec_pkg::IO_COPRO_RST) begin
			decodeBoardIo = sadec_pkg::TGT_COPRO_RST;
		end else if (a >= sadec_pkg::IO_COPRO_LO) begin
			decodeBoardIo = sadec_pkg::TGT_COPRO_PORT;
		end else begin
			decodeBoardIo = sadec_pkg::TGT_BOARD_IDLE;
		end
	endfunction

	// full i/o classification
	function automatic sadec_pkg::sadec_target_e decodeIo(input logic [9:0] a);
		if (a <= sadec_pkg::IO_BOARD_HI) begin
			decodeIo = decodeBoardIo(a);
		end else if (a >= sadec_pkg::IO_LPT1_LO && a <= sadec_pkg::IO_LPT1_HI) begin
			decodeIo = sadec_pkg::TGT_LPT1;
		end else if (a >= sadec_pkg::IO_LPT2_LO && a <= sadec_pkg::IO_LPT2_HI) begin
			decodeIo = sadec_pkg::TGT_LPT2;
		end else begin
			decodeIo = sadec_pkg::TGT_EXPANSION;
		end
	endfunction

	// targets whose cycles also run on the expansion channel
	function automatic logic onChannel(input sadec_pkg::sadec_target_e t);
		case (t)
			sadec_pkg::TGT_EXPANSION: onChannel = 1'b1;
			sadec_pkg::TGT_ADPROM:    onChannel = 1'b1;
			sadec_pkg::TGT_LPT1:      onChannel = 1'b1;
			sadec_pkg::TGT_LPT2:      onChannel = 1'b1;
			default:                  onChannel = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// current cycle decode
	// ----------------------------------------------------------------
	sadec_pkg::sadec_target_e hostTarget;
	logic                     pageWr;
	logic                     pageRd;

	// classify the cycle on the host bus
	assign hostTarget = hostCyc.isIo ? decodeIo(hostCyc.addr[9:0])
	                                 : decodeMem(hostCyc.addr, shadowAdapterEn, shadowSystemEn);
	assign pageWr = hostCyc.req && hostCyc.isIo && hostCyc.write && hostTarget == sadec_pkg::TGT_PAGE;
	assign pageRd = hostCyc.req && hostCyc.isIo && !hostCyc.write && hostTarget == sadec_pkg::TGT_PAGE;

	// ----------------------------------------------------------------
	// page register file
	// ----------------------------------------------------------------
	sadec_page_file #(
		.DATA_W (8)
	) u_page (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.wrEn    (pageWr),
		.rdEn    (pageRd),
		.offset  (hostCyc.addr[7:0]),
		.wdata   (hostCyc.wdata),
		.rdata   (ioRdata),
		.pageOut (pageOut)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------

	// width strobe filters, answer strobes and channel forwarding
	always_comb begin
		next_st = st;
		next_st.memSync = {st.memSync[1:0], memCs16_b};
		next_st.ioSync  = {st.ioSync[1:0], ioCs16_b};
		if (st.memSync[1] == st.memSync[2]) begin
			next_st.memFilt_b = st.memSync[2];
		end
		if (st.ioSync[1] == st.ioSync[2]) begin
			next_st.ioFilt_b = st.ioSync[2];
		end
		next_st.ansValid  = 1'b0;
		next_st.exp.valid = 1'b0;
		next_st.rdValid   = 1'b0;
		next_st.clrBusy   = 1'b0;
		next_st.copReset  = 1'b0;
		if (hostCyc.req) begin
			next_st.ansValid = 1'b1;
			next_st.route    = hostTarget;
			next_st.rdValid  = pageRd;
			next_st.clrBusy  = hostTarget == sadec_pkg::TGT_COPRO_CLR;
			next_st.copReset = hostTarget == sadec_pkg::TGT_COPRO_RST;
			if (onChannel(hostTarget)) begin
				next_st.exp.valid = 1'b1;
				next_st.exp.isIo  = hostCyc.isIo;
				next_st.exp.write = hostCyc.write;
				next_st.exp.addr  = hostCyc.addr;
				next_st.exp.wdata = hostCyc.wdata;
				next_st.exp.wide  = hostCyc.isIo ? !st.ioFilt_b : !st.memFilt_b;
			end
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st           <= '0;
			st.memSync   <= 3'h7;
			st.ioSync    <= 3'h7;
			st.memFilt_b <= 1'b1;
			st.ioFilt_b  <= 1'b1;
			st.route     <= sadec_pkg::TGT_NONE;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign ansValid        = st.ansValid;
	assign route           = st.route;
	assign expCyc          = st.exp;
	assign ioRdataValid    = st.rdValid;
	assign coprocClearBusy = st.clrBusy;
	assign coprocReset     = st.copReset;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_low_mem_board: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && !hostCyc.isIo && hostCyc.addr <= sadec_pkg::MEM_LOW_END
		|=> ansValid && route == sadec_pkg::TGT_SYSMEM && !expCyc.valid)
		else $error("low memory not routed on board");

	a_conv_mem_board: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && !hostCyc.isIo && hostCyc.addr >= sadec_pkg::MEM_CONV_BASE
		&& hostCyc.addr <= sadec_pkg::MEM_CONV_END
		|=> route == sadec_pkg::TGT_SYSMEM)
		else $error("conventional memory top not routed on board");

	a_rom_shadow_sel: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && !hostCyc.isIo && hostCyc.addr >= sadec_pkg::MEM_ADPROM_BASE
		&& hostCyc.addr <= sadec_pkg::MEM_BIOS_END
		|=> (route == sadec_pkg::TGT_ADPSHADOW || route == sadec_pkg::TGT_SYSSHADOW)
		== ($past(hostCyc.addr) <= sadec_pkg::MEM_ADPROM_END ? $past(shadowAdapterEn) : $past(shadowSystemEn)))
		else $error("rom window shadow select wrong");

	a_window_hidden: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && !hostCyc.isIo && hostCyc.addr >= sadec_pkg::MEM_VIDEO_BASE
		&& hostCyc.addr < sadec_pkg::MEM_EXT_BASE
		|=> ansValid && route != sadec_pkg::TGT_SYSMEM)
		else $error("board memory visible inside upper window");

	a_board_io_local: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:0] <= sadec_pkg::IO_BOARD_HI
		|=> ansValid && !expCyc.valid && route != sadec_pkg::TGT_EXPANSION)
		else $error("board i/o offered to the channel");

	a_chan_io_fwd: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:0] >= sadec_pkg::IO_CHAN_LO
		|=> expCyc.valid && expCyc.isIo && expCyc.addr == $past(hostCyc.addr)
		&& expCyc.write == $past(hostCyc.write))
		else $error("channel i/o not forwarded");

	a_dma_ctrl_sel: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:5] == 5'h06
		|=> route == sadec_pkg::TGT_DMA2)
		else $error("second dma controller not selected");

	a_pic_sel: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:5] == 5'h01
		|=> route == sadec_pkg::TGT_PIC1)
		else $error("master interrupt controller not selected");

	a_rtc_sel: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:4] == 6'h07
		|=> route == sadec_pkg::TGT_RTC)
		else $error("real time clock not selected");

	a_page_sel: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:5] == 5'h04
		|=> route == sadec_pkg::TGT_PAGE && !expCyc.valid)
		else $error("page file not selected");

	a_page_readback: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.write && hostCyc.addr[9:0] == {2'b00, sadec_pkg::PAGE_CH1}
		##1 hostCyc.req && hostCyc.isIo && !hostCyc.write && hostCyc.addr[9:0] == {2'b00, sadec_pkg::PAGE_CH1}
		|=> ioRdataValid && ioRdata == $past(hostCyc.wdata, 2) && pageOut[1] == ioRdata)
		else $error("channel 1 page register readback wrong");

	a_copro_strobe: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:0] == sadec_pkg::IO_COPRO_CLR
		|=> coprocClearBusy && !coprocReset)
		else $error("coprocessor busy clear missing");

	a_lpt_claim: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:3] == 7'h6F
		|=> route == sadec_pkg::TGT_LPT1 && expCyc.valid)
		else $error("printer port 1 not claimed");

	a_ext_mem_fwd: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && !hostCyc.isIo && hostCyc.addr >= BOARD_MEM_LIMIT
		|=> expCyc.valid && !expCyc.isIo && expCyc.addr == $past(hostCyc.addr))
		else $error("off-board memory not forwarded");

	a_width_per_cycle: assert property (@(posedge mclk) disable iff (!rst_b)
		expCyc.valid |-> expCyc.wide == (expCyc.isIo ? !$past(st.ioFilt_b) : !$past(st.memFilt_b)))
		else $error("transfer width not taken from card");

	a_unclaimed_fwd: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && !hostCyc.isIo && hostCyc.addr >= sadec_pkg::MEM_VIDEO_BASE
		&& hostCyc.addr < sadec_pkg::MEM_ADPROM_BASE
		|=> expCyc.valid && route == sadec_pkg::TGT_EXPANSION && expCyc.wdata == $past(hostCyc.wdata))
		else $error("unclaimed cycle not forwarded");

	a_dma1_sel: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:0] <= sadec_pkg::IO_DMA1_HI
		|=> route == sadec_pkg::TGT_DMA1 && !expCyc.valid)
		else $error("first dma controller not selected");

	a_pic2_sel: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:0] > sadec_pkg::IO_PAGE_HI
		&& hostCyc.addr[9:0] <= sadec_pkg::IO_PIC2_HI |=> route == sadec_pkg::TGT_PIC2)
		else $error("second interrupt controller not selected");

	a_timer_sel: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:0] > sadec_pkg::IO_PIC1_HI
		&& hostCyc.addr[9:0] <= sadec_pkg::IO_TIMER_HI |=> route == sadec_pkg::TGT_TIMER)
		else $error("interval timer not selected");

	a_kbc_sel: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:0] > sadec_pkg::IO_TIMER_HI
		&& hostCyc.addr[9:0] <= sadec_pkg::IO_KBC_HI |=> route == sadec_pkg::TGT_KBC)
		else $error("keyboard controller not selected");

	a_copro_reset: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:0] == sadec_pkg::IO_COPRO_RST
		|=> coprocReset && !coprocClearBusy)
		else $error("coprocessor reset missing");

	a_copro_port: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:0] >= sadec_pkg::IO_COPRO_LO
		&& hostCyc.addr[9:0] <= sadec_pkg::IO_BOARD_HI |=> route == sadec_pkg::TGT_COPRO_PORT)
		else $error("coprocessor port not selected");

	a_lpt2_claim: assert property (@(posedge mclk) disable iff (!rst_b)
		hostCyc.req && hostCyc.isIo && hostCyc.addr[9:0] >= sadec_pkg::IO_LPT2_LO
		&& hostCyc.addr[9:0] <= sadec_pkg::IO_LPT2_HI |=> route == sadec_pkg::TGT_LPT2 && expCyc.valid)
		else $error("printer port 2 not claimed");

endmodule // sadec_system_address_decoder

`default_nettype wire

// File: pkg/sadec_pkg.sv
/*
 * shared constants and types of the system address decoder: memory map,
 * i/o map, dma page register offsets, target enumeration and bus carriers.
 * assumes a 24-bit host address bus and 10-bit i/o decoding.
 */
// Contract
// - memory 000000-07FFFF goes to on-board system memory
// - memory 080000-09FFFF also goes to on-board memory, 640K total
// - 0C0000-0DFFFF adapter ROM, 0E0000-0FFFFF system ROM, or shadow RAM
// - on-board memory behind 640K-1M window is never reachable there
// - i/o 000-0FF decodes on board only, never offered to cards
// - i/o 100-3FF is passed to the expansion channel
// - first DMA controller at 000-01F, second at 0C0-0DF
// - master interrupt controller at 020-03F, second at 0A0-0BF
// - timer 040-05F, keyboard 060-06F, clock with NMI mask 070-07F
// - any i/o access in 080-09F selects the DMA page register file
// - fixed page register offsets per DMA channel and refresh
// - 0F0 clears coprocessor busy, 0F1 resets it, 0F8-0FF data port
// - printer port 1 at 378-37F, printer port 2 at 278-27F
// - channel carries 24-bit addresses; off-board memory above 1M reaches it
// - each channel access is 8 or 16 bits, chosen per cycle by the card

package sadec_pkg;

	// ----------------------------------------------------------------
	// memory map
	// ----------------------------------------------------------------
	localparam logic [23:0] MEM_LOW_END     = 24'h07FFFF;
	localparam logic [23:0] MEM_CONV_BASE   = 24'h080000;
	localparam logic [23:0] MEM_CONV_END    = 24'h09FFFF;
	localparam logic [23:0] MEM_VIDEO_BASE  = 24'h0A0000;
	localparam logic [23:0] MEM_ADPROM_BASE = 24'h0C0000;
	localparam logic [23:0] MEM_ADPROM_END  = 24'h0DFFFF;
	localparam logic [23:0] MEM_SYSROM_BASE = 24'h0E0000;
	localparam logic [23:0] MEM_SYSROM_END  = 24'h0EFFFF;
	localparam logic [23:0] MEM_BIOS_BASE   = 24'h0F0000;
	localparam logic [23:0] MEM_BIOS_END    = 24'h0FFFFF;
	localparam logic [23:0] MEM_EXT_BASE    = 24'h100000;
	localparam logic [23:0] MEM_BOARD_LIMIT = 24'h800000;

	// ----------------------------------------------------------------
	// i/o map, 10-bit decode
	// ----------------------------------------------------------------
	localparam logic [9:0] IO_DMA1_LO   = 10'h000;
	localparam logic [9:0] IO_DMA1_HI   = 10'h01F;
	localparam logic [9:0] IO_PIC1_HI   = 10'h03F;
	localparam logic [9:0] IO_TIMER_HI  = 10'h05F;
	localparam logic [9:0] IO_KBC_HI    = 10'h06F;
	localparam logic [9:0] IO_RTC_HI    = 10'h07F;
	localparam logic [9:0] IO_PAGE_HI   = 10'h09F;
	localparam logic [9:0] IO_PIC2_HI   = 10'h0BF;
	localparam logic [9:0] IO_DMA2_HI   = 10'h0DF;
	localparam logic [9:0] IO_COPRO_CLR = 10'h0F0;
	localparam logic [9:0] IO_COPRO_RST = 10'h0F1;
	localparam logic [9:0] IO_COPRO_LO  = 10'h0F8;
	localparam logic [9:0] IO_BOARD_HI  = 10'h0FF;
	localparam logic [9:0] IO_LPT2_LO   = 10'h278;
	localparam logic [9:0] IO_LPT2_HI   = 10'h27F;
	localparam logic [9:0] IO_LPT1_LO   = 10'h378;
	localparam logic [9:0] IO_LPT1_HI   = 10'h37F;
	localparam logic [9:0] IO_CHAN_LO   = 10'h100;
	localparam logic [9:0] IO_CHAN_HI   = 10'h3FF;

	// ----------------------------------------------------------------
	// dma page registers, offsets within 080-08F (090-09F aliases)
	// ----------------------------------------------------------------
	localparam logic [7:0] PAGE_CH0     = 8'h87;
	localparam logic [7:0] PAGE_CH1     = 8'h83;
	localparam logic [7:0] PAGE_CH2     = 8'h81;
	localparam logic [7:0] PAGE_CH3     = 8'h82;
	localparam logic [7:0] PAGE_CH5     = 8'h8B;
	localparam logic [7:0] PAGE_CH6     = 8'h89;
	localparam logic [7:0] PAGE_CH7     = 8'h8A;
	localparam logic [7:0] PAGE_REFRESH = 8'h8F;
	localparam logic [7:0] PAGE_ALIAS_MASK = 8'hEF;
	localparam int         PAGE_NUM     = 8;
	localparam logic [7:0] PAGE_RESET   = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		TGT_NONE, TGT_SYSMEM, TGT_ADPROM, TGT_ADPSHADOW, TGT_SYSROM, TGT_SYSSHADOW,
		TGT_DMA1, TGT_DMA2, TGT_PIC1, TGT_PIC2, TGT_TIMER, TGT_KBC, TGT_RTC,
		TGT_PAGE, TGT_COPRO_CLR, TGT_COPRO_RST, TGT_COPRO_PORT, TGT_BOARD_IDLE,
		TGT_LPT1, TGT_LPT2, TGT_EXPANSION
	} sadec_target_e;

	typedef struct packed {
		logic        req;
		logic        isIo;
		logic        write;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} sadec_host_cycle_s;

	typedef struct packed {
		logic        valid;
		logic        isIo;
		logic        write;
		logic [23:0] addr;
		logic [7:0]  wdata;
		logic        wide;
	} sadec_exp_cycle_s;

endpackage

// File: rtl/sadec_page_file.sv
/*
 * dma page register file: eight 8-bit page registers at fixed offsets.
 * assumes the decoder qualifies wrEn and rdEn with an i/o cycle in 080-09F.
 */
`timescale 1ns/1ps
`default_nettype none

module sadec_page_file #(
	parameter int DATA_W = 8
) (
	input  wire logic                                   mclk,
	input  wire logic                                   rst_b,
	input  wire logic                                   wrEn,
	input  wire logic                                   rdEn,
	input  wire logic [7:0]                             offset,
	input  wire logic [DATA_W-1:0]                      wdata,
	output logic      [DATA_W-1:0]                      rdata,
	output logic      [sadec_pkg::PAGE_NUM-1:0][DATA_W-1:0] pageOut
);

	typedef struct packed {
		logic [sadec_pkg::PAGE_NUM-1:0][DATA_W-1:0] page;
		logic [DATA_W-1:0]                          rdata;
	} sadec_pf_state_s;

	sadec_pf_state_s st;
	sadec_pf_state_s next_st;

	// slot lookup: {hit, index}; slot order ch0 ch1 ch2 ch3 ch5 ch6 ch7 refresh
	function automatic logic [3:0] slotOf(input logic [7:0] off);
		logic [7:0] o;
		o = off & sadec_pkg::PAGE_ALIAS_MASK;
		case (o)
			sadec_pkg::PAGE_CH0:     slotOf = 4'h8;
			sadec_pkg::PAGE_CH1:     slotOf = 4'h9;
			sadec_pkg::PAGE_CH2:     slotOf = 4'hA;
			sadec_pkg::PAGE_CH3:     slotOf = 4'hB;
			sadec_pkg::PAGE_CH5:     slotOf = 4'hC;
			sadec_pkg::PAGE_CH6:     slotOf = 4'hD;
			sadec_pkg::PAGE_CH7:     slotOf = 4'hE;
			sadec_pkg::PAGE_REFRESH: slotOf = 4'hF;
			default:                 slotOf = 4'h0;
		endcase
	endfunction

	logic [3:0] slot;
	assign slot = slotOf(offset);

	// write stores into the mapped slot, read captures it; holes read zero
	always_comb begin
		next_st = st;
		if (wrEn && slot[3]) begin
			next_st.page[slot[2:0]] = wdata;
		end
		if (rdEn) begin
			next_st.rdata = slot[3] ? st.page[slot[2:0]] : '0;
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rdata   = st.rdata;
	assign pageOut = st.page;

endmodule // sadec_page_file

`default_nettype wire

// File: dv/sadec_card_model.sv
/*
 * expansion card model: raises the 16-bit strobes as a card would per cycle.
 * assumes the bench says ahead of each cycle which width the card wants.
 */
`timescale 1ns/1ps
`default_nettype none

module sadec_card_model (
	input  wire logic mclk,
	input  wire logic memWide,
	input  wire logic ioWide,
	output logic      memCs16_b,
	output logic      ioCs16_b
);
	// active-low width request, changed just after the edge
	always @(posedge mclk) begin
		memCs16_b <= #1 ~memWide;
		ioCs16_b  <= #1 ~ioWide;
	end
endmodule // sadec_card_model
`default_nettype wire

// File: dv/test_system_address_decoder.sv
/*
 * self-checking bench of the system address decoder with a card model.
 * assumes the package constants and a one-edge answer to every request.
 */
`timescale 1ns/1ps
`default_nettype none

module test_system_address_decoder;
	localparam logic [23:0] LIM = 24'h800000;
	localparam logic [23:0] MT [0:14] = '{24'h07FFFF, 24'h080000, 24'h09FFFF, 24'h0A0000, 24'h0BFFFF,
		24'h0C0000, 24'h0DFFFF, 24'h0E0000, 24'h0EFFFF, 24'h0F0000, 24'h0FFFFF, 24'h100000,
		24'h7FFFFF, 24'h800000, 24'hFFFFFF};
	localparam logic [9:0] IT [0:31] = '{10'h000, 10'h01F, 10'h020, 10'h03F, 10'h040, 10'h05F,
		10'h060, 10'h06F, 10'h070, 10'h07F, 10'h09F, 10'h0A0, 10'h0BF, 10'h0C0, 10'h0DF, 10'h0E0,
		10'h0EF, 10'h0F0, 10'h0F1, 10'h0F2, 10'h0F7, 10'h0F8, 10'h0FF, 10'h100, 10'h277, 10'h278,
		10'h27F, 10'h280, 10'h378, 10'h37F, 10'h380, 10'h3FF};
	localparam logic [7:0] OFS [0:7] = '{8'h87, 8'h83, 8'h81, 8'h82, 8'h8B, 8'h89, 8'h8A, 8'h8F};
	logic mclk, rst_b, shA, shS, mw, iw, memCs16_b, ioCs16_b, ansValid, ioRdataValid, clr, rst;
	sadec_pkg::sadec_host_cycle_s hc;
	sadec_pkg::sadec_target_e route;
	sadec_pkg::sadec_exp_cycle_s expCyc;
	logic [7:0] ioRdata;
	logic [7:0][7:0] pageOut;
	logic [7:0] pg [0:7];
	int err_total, n_tests, seed, i, k;
	logic [31:0] r;

	sadec_system_address_decoder #(.BOARD_MEM_LIMIT(LIM)) i_sadec_system_address_decoder (
		.mclk(mclk), .rst_b(rst_b), .hostCyc(hc), .shadowAdapterEn(shA), .shadowSystemEn(shS),
		.memCs16_b(memCs16_b), .ioCs16_b(ioCs16_b), .ansValid(ansValid), .route(route),
		.expCyc(expCyc), .ioRdataValid(ioRdataValid), .ioRdata(ioRdata), .coprocClearBusy(clr),
		.coprocReset(rst), .pageOut(pageOut));
	sadec_card_model i_sadec_card_model (.mclk(mclk), .memWide(mw), .ioWide(iw),
		.memCs16_b(memCs16_b), .ioCs16_b(ioCs16_b));

	// ------------------------------------------------------------
	// reference model
	// ------------------------------------------------------------
	function automatic sadec_pkg::sadec_target_e expRoute(input logic io, input logic [23:0] a);
		int p;
		p = int'(a[9:0]);
		if (!io) begin
			if (a < 24'h0A0000) return sadec_pkg::TGT_SYSMEM;
			if (a < 24'h0C0000) return sadec_pkg::TGT_EXPANSION;
			if (a < 24'h0E0000) return shA ? sadec_pkg::TGT_ADPSHADOW : sadec_pkg::TGT_ADPROM;
			if (a < 24'h100000) return shS ? sadec_pkg::TGT_SYSSHADOW : sadec_pkg::TGT_SYSROM;
			return (a < LIM) ? sadec_pkg::TGT_SYSMEM : sadec_pkg::TGT_EXPANSION;
		end
		if (p <= 'h1F) return sadec_pkg::TGT_DMA1;
		if (p <= 'h3F) return sadec_pkg::TGT_PIC1;
		if (p <= 'h5F) return sadec_pkg::TGT_TIMER;
		if (p <= 'h6F) return sadec_pkg::TGT_KBC;
		if (p <= 'h7F) return sadec_pkg::TGT_RTC;
		if (p <= 'h9F) return sadec_pkg::TGT_PAGE;
		if (p <= 'hBF) return sadec_pkg::TGT_PIC2;
		if (p <= 'hDF) return sadec_pkg::TGT_DMA2;
		if (p == 'hF0) return sadec_pkg::TGT_COPRO_CLR;
		if (p == 'hF1) return sadec_pkg::TGT_COPRO_RST;
		if (p >= 'hF8 && p <= 'hFF) return sadec_pkg::TGT_COPRO_PORT;
		if (p <= 'hFF) return sadec_pkg::TGT_BOARD_IDLE;
		if (p >= 'h278 && p <= 'h27F) return sadec_pkg::TGT_LPT2;
		if (p >= 'h378 && p <= 'h37F) return sadec_pkg::TGT_LPT1;
		return sadec_pkg::TGT_EXPANSION;
	endfunction

	// ------------------------------------------------------------
	// checks and stimulus
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one request, held high for back-to-back use, checked one edge later
	task automatic cyc(input logic io, input logic wr, input logic [23:0] a);
		sadec_pkg::sadec_target_e t;
		logic [7:0] d;
		logic f;
		int x, j;
		d = 8'($random(seed));
		hc = '{req: 1'b1, isIo: io, write: wr, addr: a, wdata: d};
		t = expRoute(io, a);
		f = t inside {sadec_pkg::TGT_EXPANSION, sadec_pkg::TGT_ADPROM, sadec_pkg::TGT_LPT1, sadec_pkg::TGT_LPT2};
		x = -1;
		for (j = 0; j < 8; j++)
			if ((a[7:0] & 8'hEF) == OFS[j]) x = j;
		if (t == sadec_pkg::TGT_PAGE && wr && x >= 0) pg[x] = d;
		@(posedge mclk);
		#1;
		chk("ansValid", 1, ansValid);
		chk("route", t, route);
		chk("expValid", f, expCyc.valid);
		if (f) begin
			chk("expAddr", a, expCyc.addr);
			chk("expKind", {io, wr, d}, {expCyc.isIo, expCyc.write, expCyc.wdata});
			chk("expWide", io ? iw : mw, expCyc.wide);
		end
		chk("clrBusy", t == sadec_pkg::TGT_COPRO_CLR, clr);
		chk("coprRst", t == sadec_pkg::TGT_COPRO_RST, rst);
		chk("rdValid", t == sadec_pkg::TGT_PAGE && !wr, ioRdataValid);
		if (t == sadec_pkg::TGT_PAGE && !wr) chk("ioRdata", (x >= 0) ? pg[x] : 8'h00, ioRdata);
		for (j = 0; j < 8; j++) chk("pageOut", pg[j], pageOut[j]);
	endtask

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	initial begin
		#500000;
		err_total++;
		final_report;
	end

	initial begin
		hc = '0;
		{shA, shS, mw, iw} = 4'h0;
		rst_b = 1'b0;
		seed = 32'hF4F35FDF;
		for (i = 0; i < 8; i++) pg[i] = 8'h00;
		repeat (5) @(posedge mclk);
		#1 rst_b = 1'b1;
		@(posedge mclk);
		#1;
		chk("rstRoute", sadec_pkg::TGT_NONE, route);
		chk("rstExp", 0, expCyc.valid);
		for (k = 0; k < 6; k++) begin
			r = $random(seed);
			{shA, shS, mw, iw} = r[3:0];
			repeat (8) @(posedge mclk);
			#1;
			for (i = 0; i < 15; i++) cyc(1'b0, r[i+4], MT[i]);
			for (i = 0; i < 32; i++) cyc(1'b1, 1'b0, {14'($random(seed)), IT[i]});
			for (i = 0; i < 8; i++) begin
				cyc(1'b1, 1'b1, {16'h0, OFS[i]});
				cyc(1'b1, 1'b0, {16'h0, OFS[i] | 8'h10});
			end
			cyc(1'b1, 1'b1, 24'h000084);
			cyc(1'b1, 1'b1, 24'h000083);
			cyc(1'b1, 1'b0, 24'h000083);
			for (i = 0; i < 20; i++) begin
				r = $random(seed);
				cyc(r[31], r[30], r[23:0]);
			end
			hc.req = 1'b0;
		end
		final_report;
	end
endmodule // test_system_address_decoder
`default_nettype wire
